// >>> bench/testbench.sv
// Self-checking testbench for the arithmetic, skip and jump execution unit
`timescale 1ns/1ps
`include "incdec_exec_defs.svh"
module testbench import incdec_exec_pkg::*;;
  // ------------------------------------------------------------
  // Stimulus and observed signals
  // ------------------------------------------------------------
  logic core_clk_i = 1'b0;
  logic rstn_i = 1'b0;
  logic q4_i = 1'b0;
  logic [15:0] instr_i = 16'h0000;
  logic instr_two_word_i = 1'b0;
  logic [7:0] bank_select_register_i = 8'h25;
  logic [7:0] file_rdata_i = 8'h00;
  logic [11:0] file_addr_o;
  logic file_we_o;
  logic [7:0] file_wdata_o;
  logic [7:0] work_o;
  logic [4:0] status_o;
  logic [20:0] pc_o;
  logic pc_load_o;
  logic idle_slot_o;
  logic [11:0] addr_seen;
  int errors = 0;
  int check_count = 0;

  always #20 core_clk_i = ~core_clk_i;

  incdec_exec incdec_exec_inst (
    .core_clk_i(core_clk_i), .rstn_i(rstn_i), .q4_i(q4_i), .instr_i(instr_i),
    .instr_two_word_i(instr_two_word_i), .bank_select_register_i(bank_select_register_i),
    .file_rdata_i(file_rdata_i), .file_addr_o(file_addr_o), .file_we_o(file_we_o),
    .file_wdata_o(file_wdata_o), .work_o(work_o), .status_o(status_o), .pc_o(pc_o),
    .pc_load_o(pc_load_o), .idle_slot_o(idle_slot_o)
  );

  // ------------------------------------------------------------
  // Shared tasks
  // ------------------------------------------------------------
  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    check_count++;
    if (got !== exp) begin
      errors++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : check

  task automatic finish_test();
    $display("Checks %0d, mismatches %0d", check_count, errors);
    if (errors == 0 && check_count > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask : finish_test

  // One instruction cycle; the gap keeps q4 at one pulse in four clocks
  task automatic ex(input logic [15:0] ins, input logic [7:0] rd);
    repeat (3) @(posedge core_clk_i);
    #1;
    instr_i = ins;
    file_rdata_i = rd;
    q4_i = 1'b1;
    #1 addr_seen = file_addr_o;
    @(posedge core_clk_i);
    #1 q4_i = 1'b0;
  endtask : ex

  // ------------------------------------------------------------
  // Scenarios
  // ------------------------------------------------------------
  task automatic t_daw();
    logic [7:0] rd [4] = '{8'ha4, 8'hcd, 8'h0f, 8'hff};
    logic [7:0] w [4] = '{8'h05, 8'h34, 8'h16, 8'h66};
    logic c [4] = '{1'b1, 1'b1, 1'b0, 1'b1};
    logic [4:0] s;
    for (int i = 0; i < 4; i++) begin
      ex({`OPC6_INCREMENT_FILE, 2'b01, 8'h10}, rd[i]);
      s = status_o;
      ex(`OPC_DECIMAL_ADJUST, 8'h00);
      check(work_o[3:0], w[i][3:0]);
      check(work_o[7:4], w[i][7:4]);
      check(status_o[`FLAG_CARRY], c[i]);
      check(status_o[4:2], s[4:2]);
      check(idle_slot_o, 1'b0);
    end
    $display("decimal adjust test done");
  endtask : t_daw

  task automatic t_incdec();
    logic [5:0] op [6] = '{`OPC6_INCREMENT_FILE, `OPC6_INCREMENT_FILE, `OPC6_INCREMENT_FILE,
                           `OPC6_DECREMENT_FILE, `OPC6_DECREMENT_FILE, `OPC6_DECREMENT_FILE};
    logic [7:0] rd [6] = '{8'hff, 8'h7f, 8'h0e, 8'h01, 8'h00, 8'h80};
    logic [7:0] w [6] = '{8'h00, 8'h80, 8'h0f, 8'h00, 8'hff, 8'h7f};
    logic [4:0] st [6] = '{5'h07, 5'h1a, 5'h00, 5'h07, 5'h10, 5'h09};
    for (int i = 0; i < 6; i++) begin
      ex({op[i], 2'b00, 8'h80}, rd[i]);
      check(addr_seen, 12'h080);
      check({work_o, status_o, file_we_o}, {w[i], st[i], 1'b0});
    end
    // Bank taken from the select register; result goes back to the file
    ex({`OPC6_INCREMENT_FILE, 2'b11, 8'h34}, 8'h41);
    check(addr_seen, 12'h534);
    check({file_we_o, file_wdata_o, work_o}, {1'b1, 8'h42, 8'h7f});
    ex({`OPC6_DECREMENT_FILE, 2'b11, 8'h34}, 8'h41);
    check({file_we_o, file_wdata_o, work_o}, {1'b1, 8'h40, 8'h7f});
    $display("increment and decrement test done");
  endtask : t_incdec

  task automatic t_skip();
    logic [5:0] op [6] = '{`OPC6_INC_SKIP_ZERO, `OPC6_INC_SKIP_ZERO, `OPC6_DEC_SKIP_ZERO,
                           `OPC6_DEC_SKIP_ZERO, `OPC6_DEC_SKIP_NONZERO, `OPC6_DEC_SKIP_NONZERO};
    logic [7:0] rd [6] = '{8'hff, 8'h05, 8'h01, 8'h05, 8'h05, 8'h01};
    logic [7:0] w [6] = '{8'h00, 8'h06, 8'h00, 8'h04, 8'h04, 8'h00};
    logic skp [6] = '{1'b1, 1'b0, 1'b1, 1'b0, 1'b1, 1'b0};
    logic [4:0] s;
    int n;
    for (int tw = 0; tw < 2; tw++) begin
      for (int i = 0; i < 6; i++) begin
        instr_two_word_i = tw[0];
        s = status_o;
        ex({op[i], 2'b00, 8'h11}, rd[i]);
        instr_two_word_i = 1'b0;
        check(work_o, w[i]);
        check(status_o, s);
        n = 0;
        while (idle_slot_o === 1'b1 && n < 4) begin
          ex(16'h0000, 8'h00);
          n++;
        end
        check(n, skp[i] ? 1 + tw : 0);
      end
    end
    $display("skip test done");
  endtask : t_skip

  task automatic t_jump(input logic [19:0] k);
    ex({`OPC8_JUMP_FIRST, k[7:0]}, 8'h00);
    check({idle_slot_o, pc_load_o}, 2'b10);
    ex({`OPC4_SECOND_WORD, k[19:8]}, 8'h00);
    check(pc_load_o, 1'b1);
    check(pc_o, {k, 1'b0});
    check(idle_slot_o, 1'b0);
    $display("jump test done");
  endtask : t_jump

  // ------------------------------------------------------------
  // Main sequence and watchdog
  // ------------------------------------------------------------
  initial begin
    repeat (2) @(posedge core_clk_i);
    #1 rstn_i = 1'b1;
    t_daw();
    t_incdec();
    t_skip();
    t_jump(20'ha5c3b);
    t_jump(20'hfffff);
    finish_test();
  end

  // Whole run needs well under a thousand clocks
  initial begin
    #200000;
    errors++;
    finish_test();
  end
endmodule : testbench

// >>> hw/incdec_exec.sv
// Execution unit for decimal adjust, increment/decrement, skips and absolute jump
`timescale 1ns/1ps
`include "incdec_exec_defs.svh"

// Behaviour
// (RULE1) Low nibble plus 6 if >9 or half carry
// (RULE2) High nibble plus 6 if >9 or carry
// (RULE3) Decimal adjust touches only carry, half carry
// (RULE4) Decimal adjust decoded, one cycle, writes working
// (RULE5) Decrement file, destination bit, five flags updated
// (RULE6) Access bit zero selects access bank
// (RULE7) Increment file, destination bit, five flags updated
// (RULE8) Increment skip zero: no flags, flush next
// (RULE9) Decrement skip nonzero: no flags, flush next
// (RULE10) Skips take 1, 2 or 3 cycles
// (RULE11) Jump loads 20 bits into PC 20:1
// (RULE12) Jump two words, second cycle idle
// (RULE13) Decrement skip zero: no flags, flush next
module incdec_exec
  import incdec_exec_pkg::*;
#(
  parameter int PC_W = 21
) (
  input wire logic core_clk_i,
  input wire logic rstn_i,
  input wire logic q4_i,
  input wire logic [15:0] instr_i,
  input wire logic instr_two_word_i,
  input wire logic [7:0] bank_select_register_i,
  input wire logic [7:0] file_rdata_i,
  output logic [11:0] file_addr_o,
  output logic file_we_o,
  output logic [7:0] file_wdata_o,
  output logic [7:0] work_o,
  output logic [4:0] status_o,
  output logic [PC_W-1:0] pc_o,
  output logic pc_load_o,
  output logic idle_slot_o
);

  // ----------------------------------------------------------------
  // Decode
  // ----------------------------------------------------------------
  exec_state_t state_ff;
  logic [7:0] work_ff;
  logic [4:0] status_ff;
  logic [PC_W-1:0] pc_ff;
  logic pc_load_ff;
  logic [7:0] jump_low_ff;
  logic [1:0] flush_left_ff;
  logic file_we_ff;
  logic [7:0] file_wdata_ff;
  logic [11:0] file_addr_ff;

  logic [5:0] op6;
  logic dst_file;
  logic is_daw, is_dec, is_inc, is_dsz, is_isz, is_dsnz, is_jump1;
  logic is_file_op, is_up, is_skip_op;

  assign op6 = instr_i[15:10];
  assign dst_file = instr_i[9];
  assign is_daw = (instr_i == `OPC_DECIMAL_ADJUST); // see (RULE4)
  assign is_dec = (op6 == `OPC6_DECREMENT_FILE);
  assign is_inc = (op6 == `OPC6_INCREMENT_FILE);
  assign is_dsz = (op6 == `OPC6_DEC_SKIP_ZERO);
  assign is_isz = (op6 == `OPC6_INC_SKIP_ZERO);
  assign is_dsnz = (op6 == `OPC6_DEC_SKIP_NONZERO);
  assign is_jump1 = (instr_i[15:8] == `OPC8_JUMP_FIRST);
  assign is_up = is_inc | is_isz;
  assign is_skip_op = is_dsz | is_isz | is_dsnz;
  assign is_file_op = is_dec | is_inc | is_skip_op;

  // ----------------------------------------------------------------
  // Operand and result
  // ----------------------------------------------------------------
  logic [11:0] nxt_addr;
  logic [8:0] sum;
  logic [4:0] half_sum;
  logic [7:0] res;
  logic res_zero;
  logic wrap;
  logic take_skip;

  // Access bank when access bit is low, otherwise banked
  assign nxt_addr = instr_i[8] ? {bank_select_register_i[3:0], instr_i[7:0]}
                               : {`ACCESS_BANK, instr_i[7:0]}; // see (RULE6)
  // Decrement is add of all ones so carry means no borrow
  assign sum = is_up ? ({1'b0, file_rdata_i} + 9'h001) : ({1'b0, file_rdata_i} + 9'h0ff); // see (RULE5) (RULE7)
  assign half_sum = is_up ? ({1'b0, file_rdata_i[3:0]} + 5'h01) : ({1'b0, file_rdata_i[3:0]} + 5'h0f);
  assign res = sum[7:0];
  assign res_zero = (res == 8'h00);
  assign wrap = is_up ? (file_rdata_i == 8'h7f) : (file_rdata_i == 8'h80);
  assign take_skip = ((is_dsz | is_isz) & res_zero) | (is_dsnz & ~res_zero); // see (RULE8) (RULE9) (RULE13)

  // Decimal adjust
  logic lo_adj, hi_adj;
  logic [4:0] lo_sum;
  logic [4:0] hi_sum;
  logic [7:0] daw_res;
  assign lo_adj = (work_ff[3:0] > `BCD_LIMIT) | status_ff[`FLAG_HALF]; // see (RULE1)
  assign hi_adj = (work_ff[7:4] > `BCD_LIMIT) | status_ff[`FLAG_CARRY]; // see (RULE2)
  assign lo_sum = lo_adj ? ({1'b0, work_ff[3:0]} + {1'b0, `BCD_ADJUST}) : {1'b0, work_ff[3:0]};
  // Low nibble carry ripples up so the packed pair stays one decimal value
  assign hi_sum = {1'b0, work_ff[7:4]} + (hi_adj ? {1'b0, `BCD_ADJUST} : 5'h00) + {4'h0, lo_sum[4]};
  assign daw_res = {hi_sum[3:0], lo_sum[3:0]};

  // ----------------------------------------------------------------
  // Sequencing
  // ----------------------------------------------------------------
  logic run_exec;
  assign run_exec = q4_i & (state_ff == ST_RUN);

  always_ff @(posedge core_clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      state_ff <= ST_RUN;
      flush_left_ff <= 2'h0;
      jump_low_ff <= 8'h00;
    end else if (q4_i) begin
      unique case (state_ff)
        ST_RUN: begin
          if (is_file_op && take_skip) begin
            state_ff <= ST_FLUSH; // see (RULE10)
            flush_left_ff <= instr_two_word_i ? 2'h1 : 2'h0;
          end else if (is_jump1) begin
            state_ff <= ST_JUMP2;
            jump_low_ff <= instr_i[7:0];
          end
        end
        ST_FLUSH: begin
          // Each flushed word is one full idle cycle
          if (flush_left_ff == 2'h0) begin
            state_ff <= ST_RUN;
          end else begin
            flush_left_ff <= flush_left_ff - 2'h1; // see (RULE10)
          end
        end
        ST_JUMP2: begin
          state_ff <= ST_RUN; // see (RULE12)
        end
        default: begin
          state_ff <= ST_RUN;
        end
      endcase
    end
  end

  always_ff @(posedge core_clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      pc_ff <= '0;
      pc_load_ff <= 1'b0;
    end else begin
      pc_load_ff <= 1'b0;
      if (q4_i && state_ff == ST_JUMP2 && instr_i[15:12] == `OPC4_SECOND_WORD) begin
        pc_ff <= {instr_i[11:0], jump_low_ff, 1'b0}; // see (RULE11) (RULE12)
        pc_load_ff <= 1'b1;
      end
    end
  end

  always_ff @(posedge core_clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      work_ff <= 8'h00;
    end else if (run_exec) begin
      if (is_daw) begin
        work_ff <= daw_res; // see (RULE4)
      end else if (is_file_op && !dst_file) begin
        work_ff <= res;
      end
    end
  end

  always_ff @(posedge core_clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      status_ff <= 5'h00;
    end else if (run_exec) begin
      if (is_daw) begin
        // Carry only ever sets here, never clears a prior carry
        status_ff[`FLAG_CARRY] <= status_ff[`FLAG_CARRY] | hi_sum[4]; // see (RULE3)
        status_ff[`FLAG_HALF] <= lo_sum[4]; // see (RULE3)
      end else if (is_dec || is_inc) begin
        status_ff[`FLAG_CARRY] <= sum[8]; // see (RULE5) (RULE7)
        status_ff[`FLAG_HALF] <= half_sum[4];
        status_ff[`FLAG_ZERO] <= res_zero;
        status_ff[`FLAG_WRAP] <= wrap;
        status_ff[`FLAG_NEG] <= res[7];
      end
    end
  end

  always_ff @(posedge core_clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      file_we_ff <= 1'b0;
      file_wdata_ff <= 8'h00;
      file_addr_ff <= 12'h000;
    end else begin
      file_we_ff <= run_exec & is_file_op & dst_file; // see (RULE5) (RULE7)
      if (run_exec && is_file_op) begin
        file_wdata_ff <= res;
        file_addr_ff <= nxt_addr;
      end
    end
  end

  assign file_addr_o = (state_ff == ST_RUN) ? nxt_addr : file_addr_ff;
  assign file_we_o = file_we_ff;
  assign file_wdata_o = file_wdata_ff;
  assign work_o = work_ff;
  assign status_o = status_ff;
  assign pc_o = pc_ff;
  assign pc_load_o = pc_load_ff;
  assign idle_slot_o = (state_ff != ST_RUN);

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  property p_skip_flags_kept;
    @(posedge core_clk_i) disable iff (!rstn_i)
      (run_exec && is_skip_op) |=> $stable(status_o);
  endproperty
  a_skip_flags_kept: assert property (p_skip_flags_kept) else $error("skip changed flags"); // see (RULE8)

  property p_isz_flush;
    @(posedge core_clk_i) disable iff (!rstn_i)
      (run_exec && is_isz && res_zero) |=> idle_slot_o;
  endproperty
  a_isz_flush: assert property (p_isz_flush) else $error("zero increment did not skip"); // see (RULE8)

  property p_dsnz_flush;
    @(posedge core_clk_i) disable iff (!rstn_i)
      (run_exec && is_dsnz && !res_zero) |=> idle_slot_o;
  endproperty
  a_dsnz_flush: assert property (p_dsnz_flush) else $error("nonzero decrement did not skip"); // see (RULE9)

  property p_dsz_noskip;
    @(posedge core_clk_i) disable iff (!rstn_i)
      (run_exec && is_dsz && !res_zero) |=> !idle_slot_o;
  endproperty
  a_dsz_noskip: assert property (p_dsz_noskip) else $error("nonzero decrement skipped"); // see (RULE13)

  property p_daw_carry_sticky;
    @(posedge core_clk_i) disable iff (!rstn_i)
      (run_exec && is_daw && status_ff[`FLAG_CARRY]) |=> status_o[`FLAG_CARRY];
  endproperty
  a_daw_carry_sticky: assert property (p_daw_carry_sticky) else $error("adjust cleared carry"); // see (RULE3)

  property p_daw_result;
    @(posedge core_clk_i) disable iff (!rstn_i)
      (run_exec && is_daw) |=> (work_o == $past(daw_res));
  endproperty
  a_daw_result: assert property (p_daw_result) else $error("adjust result wrong"); // see (RULE1)

  property p_dec_zero_flag;
    @(posedge core_clk_i) disable iff (!rstn_i)
      (run_exec && is_dec && file_rdata_i == 8'h01) |=> status_o[`FLAG_ZERO];
  endproperty
  a_dec_zero_flag: assert property (p_dec_zero_flag) else $error("decrement to zero no zero flag"); // see (RULE5)

  property p_inc_to_work;
    @(posedge core_clk_i) disable iff (!rstn_i)
      (run_exec && is_inc && !dst_file) |=> (work_o == $past(res)) && !file_we_o;
  endproperty
  a_inc_to_work: assert property (p_inc_to_work) else $error("increment destination wrong"); // see (RULE7)

  property p_access_bank;
    @(posedge core_clk_i) disable iff (!rstn_i)
      (state_ff == ST_RUN && !instr_i[8]) |-> (file_addr_o == {`ACCESS_BANK, instr_i[7:0]});
  endproperty
  a_access_bank: assert property (p_access_bank) else $error("access bank not selected"); // see (RULE6)

  property p_jump_two_cycles;
    @(posedge core_clk_i) disable iff (!rstn_i)
      (run_exec && is_jump1) |=> idle_slot_o;
  endproperty
  a_jump_two_cycles: assert property (p_jump_two_cycles) else $error("jump second cycle not idle"); // see (RULE12)

  property p_dsz_flush;
    @(posedge core_clk_i) disable iff (!rstn_i)
      (run_exec && is_dsz && res_zero) |=> idle_slot_o;
  endproperty
  a_dsz_flush: assert property (p_dsz_flush) else $error("zero decrement did not skip"); // see (RULE13)

  property p_isz_noskip;
    @(posedge core_clk_i) disable iff (!rstn_i)
      (run_exec && is_isz && !res_zero) |=> !idle_slot_o;
  endproperty
  a_isz_noskip: assert property (p_isz_noskip) else $error("nonzero increment skipped"); // see (RULE8)

  property p_dsnz_noskip;
    @(posedge core_clk_i) disable iff (!rstn_i)
      (run_exec && is_dsnz && res_zero) |=> !idle_slot_o;
  endproperty
  a_dsnz_noskip: assert property (p_dsnz_noskip) else $error("zero decrement skipped"); // see (RULE9)

  property p_skip_extra_word;
    @(posedge core_clk_i) disable iff (!rstn_i)
      (run_exec && is_file_op && take_skip && instr_two_word_i) |=> idle_slot_o && (flush_left_ff == 2'h1);
  endproperty
  a_skip_extra_word: assert property (p_skip_extra_word) else $error("two word skip too short"); // see (RULE10)

  property p_jump_pc_load;
    @(posedge core_clk_i) disable iff (!rstn_i)
      (q4_i && state_ff == ST_JUMP2 && instr_i[15:12] == `OPC4_SECOND_WORD) |=>
        pc_load_o && (pc_o == {$past(instr_i[11:0]), $past(jump_low_ff), 1'b0});
  endproperty
  a_jump_pc_load: assert property (p_jump_pc_load) else $error("jump target not loaded"); // see (RULE11)

  property p_dec_to_file;
    @(posedge core_clk_i) disable iff (!rstn_i)
      (run_exec && is_dec && dst_file) |=> file_we_o && (file_wdata_o == $past(res)) && $stable(work_o);
  endproperty
  a_dec_to_file: assert property (p_dec_to_file) else $error("decrement destination wrong"); // see (RULE5)

endmodule : incdec_exec

// >>> pkg/incdec_exec_defs.svh
// Encodings, flag positions and access bank and BCD constants for the arithmetic/skip/jump execution unit
`ifndef INCDEC_EXEC_DEFS_SVH
`define INCDEC_EXEC_DEFS_SVH
`define OPC_DECIMAL_ADJUST 16'h0007
`define OPC6_DECREMENT_FILE 6'h01
`define OPC6_INCREMENT_FILE 6'h0a
`define OPC6_DEC_SKIP_ZERO 6'h0b
`define OPC6_INC_SKIP_ZERO 6'h0f
`define OPC6_DEC_SKIP_NONZERO 6'h13
`define OPC8_JUMP_FIRST 8'hef
`define OPC4_SECOND_WORD 4'hf
`define FLAG_CARRY 0
`define FLAG_HALF 1
`define FLAG_ZERO 2
`define FLAG_WRAP 3
`define FLAG_NEG 4
`define ACCESS_BANK 4'h0
`define BCD_LIMIT 4'h9
`define BCD_ADJUST 4'h6
`endif

// >>> pkg/incdec_exec_pkg.sv
// Types for the arithmetic/skip/jump execution unit
package incdec_exec_pkg;
  typedef enum logic [2:0] {
    ST_RUN = 3'b001,
    ST_FLUSH = 3'b010,
    ST_JUMP2 = 3'b100
  } exec_state_t;
endpackage : incdec_exec_pkg
